// [logic/pewl_top.v]
// Power event wake logic: wake sources, sticky status, enables and the
// event output pin, plus the specific-key matcher.
// Assumes a simple synchronous register port on CORE_CLK and async pins.
//
// How it works
// - Ring, keyboard, mouse, GPIO, fan events assert output
// - Polarity bit selects active high or low
// - Bit 7 selects open-drain or push-pull
// - Reset default: active low, open drain
// - Global enable gates output; enabled pending asserts
// - Status sets regardless of global enable
// - Aggregate status is OR of enabled statuses
// - Write one clears status; zero keeps it
// - GPIO edge chosen by polarity, rising default
// - Dual-edge mode sets status on both edges
// - Fan status and enable valid with main power
// - Scan code at 0x11, standby reset only
// - Key wake status and enable at bit 5
// - Start bit after at least 115 us clock-high idle
// - Compare data on tenth falling edge
// - Accept only odd parity over data plus parity
// - Match with stop one sets key status
// - Return to idle after eleven clocks
// - Long clock-high mid-frame abandons the frame
// - Slow-clock bit 1 switches matcher off
// - Key wake needs its enable bit
// - GPIO status clears on write of one
`include "pewl_consts.vh"
module pewl_top #(
    parameter GPIO_N = 8,
    parameter IDLE_TICKS = (`PEWL_IDLE_MIN_US * `PEWL_SLOW_CLK_HZ + 999999) / 1000000
) (
    // Clock and resets
    input wire CORE_CLK,
    input wire RESET,
    input wire STANDBY_RESET,
    input wire MAIN_POWER_OK,
    // Register port
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    // Wake source pins
    input wire RING_INDICATOR_A_N,
    input wire RING_INDICATOR_B_N,
    input wire KBD_DATA,
    input wire KBD_CLK,
    input wire MOUSE_DATA,
    input wire FAN_EVENT,
    input wire [GPIO_N-1:0] GPIO_IN,
    // Slow clock input
    input wire SLOW_CLK,
    // Power event output pin
    output wire POWER_EVENT_OUT,
    output wire POWER_EVENT_OE
);
    reg [7:0] wake_scan_code;
    reg [7:0] event_output_control;
    reg [7:0] slow_clock_control;
    reg [7:0] wake_enable_first;
    reg [7:0] wake_status_first;
    reg [GPIO_N-1:0] gpio_status;
    reg [GPIO_N-1:0] gpio_enable;
    reg [GPIO_N-1:0] gpio_pol;
    reg [GPIO_N-1:0] dual_edge_wake;
    reg global_event_enable;
    wire aggregate_event_status;
    wire key_wake_off;
    wire [5:0] s_level;
    wire [5:0] s_rise;
    wire [5:0] s_fall;
    wire [GPIO_N-1:0] g_rise;
    wire [GPIO_N-1:0] g_fall;
    wire [GPIO_N-1:0] gpio_evt;
    wire [7:0] evt_first;
    wire key_match;
    wire wr_sts1;
    wire wr_sts2;
    wire wr_scan;
    wire wr_ctl;
    wire wr_slow;
    wire wr_en1;
    wire wr_en2;
    wire wr_pol;
    wire wr_dual;
    wire wr_glob;
    wire key_tick;
    reg pwr_meta;
    reg pwr_ok;
    reg [7:0] next_status_first;
    reg [GPIO_N-1:0] next_gpio_status;
    reg next_out;
    reg next_oe;

    // Strobe-style write decode, reused by every register
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // Zero-extend a GPIO field to the byte-wide read port;
    // GPIO_N above 8 is not supported by the read map
    function [7:0] pad;
        input [GPIO_N-1:0] v;
        begin
            pad = 8'h00;
            pad[GPIO_N-1:0] = v;
        end
    endfunction

    // Synchronise the single-bit wake and clock pins except ring A; ring inputs are active low
    pewl_edge_detect #(.WIDTH(6)) u_pins (
        .clk(CORE_CLK),
        .rst(RESET),
        .pin({SLOW_CLK, KBD_CLK, FAN_EVENT, MOUSE_DATA, KBD_DATA,
            RING_INDICATOR_B_N}),
        .level(s_level),
        .rise(s_rise),
        .fall(s_fall)
    );

    // Ring A uses its own sync so the vector stays readable
    wire ring_a_fall;
    pewl_edge_detect #(.WIDTH(1)) u_ring_a (
        .clk(CORE_CLK),
        .rst(RESET),
        .pin(RING_INDICATOR_A_N),
        .level(),
        .rise(),
        .fall(ring_a_fall)
    );

    pewl_edge_detect #(.WIDTH(GPIO_N)) u_gpio (
        .clk(CORE_CLK),
        .rst(RESET),
        .pin(GPIO_IN),
        .level(),
        .rise(g_rise),
        .fall(g_fall)
    );

    // Main power comes from another supply domain: two flops first
    always @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            pwr_meta <= 1'b0;
            pwr_ok <= 1'b0;
        end
        else
        begin
            pwr_meta <= MAIN_POWER_OK;
            pwr_ok <= pwr_meta;
        end
    end

    // Matcher is off when the control bit is one; its tick is gated too
    assign key_wake_off = slow_clock_control[`PEWL_BIT_KEY_OFF];
    // No ticks while off, so the matcher sits still and saves power
    assign key_tick = s_rise[5] & ~key_wake_off;
    pewl_key_match #(.IDLE_TICKS(IDLE_TICKS)) u_key (
        .clk(CORE_CLK),
        .rst(RESET),
        .enable(~key_wake_off),
        .slow_tick(key_tick),
        .kbd_clk(s_level[4]),
        .kbd_clk_fall(s_fall[4]),
        .kbd_data(s_level[1]),
        .scan_code(wake_scan_code),
        .match(key_match)
    );

    // Active transitions: ring falls, kbd/mouse data falls, fan pulses
    assign evt_first = {2'b00,
        key_match,
        s_rise[3] & pwr_ok,
        s_fall[2],
        s_fall[1],
        s_fall[0],
        ring_a_fall};

    // GPIO edge select: polarity picks edge unless dual-edge is on
    assign gpio_evt = (dual_edge_wake & (g_rise | g_fall))
        | (~dual_edge_wake & ~gpio_pol & g_rise)
        | (~dual_edge_wake & gpio_pol & g_fall);

    // One decode per register, shared by the write processes
    assign wr_sts1 = REG_WR && hit(REG_ADDR, `PEWL_OFS_STS1);
    assign wr_sts2 = REG_WR && hit(REG_ADDR, `PEWL_OFS_STS2);
    assign wr_scan = REG_WR && hit(REG_ADDR, `PEWL_OFS_SCAN_CODE);
    assign wr_ctl = REG_WR && hit(REG_ADDR, `PEWL_OFS_EVT_OUT_CTRL);
    assign wr_slow = REG_WR && hit(REG_ADDR, `PEWL_OFS_SLOW_CLK_CTRL);
    assign wr_en1 = REG_WR && hit(REG_ADDR, `PEWL_OFS_EN1);
    assign wr_en2 = REG_WR && hit(REG_ADDR, `PEWL_OFS_EN2);
    assign wr_pol = REG_WR && hit(REG_ADDR, `PEWL_OFS_GPIO_POL);
    assign wr_dual = REG_WR && hit(REG_ADDR, `PEWL_OFS_GPIO_DUAL);
    assign wr_glob = REG_WR && hit(REG_ADDR, `PEWL_OFS_GLOBAL);

    // Next status: a new event wins over a same-cycle clear,
    // so an edge landing on the clear is never lost
    always @*
    begin
        next_status_first = wake_status_first;
        next_gpio_status = gpio_status;
        if (wr_sts1)
            next_status_first = next_status_first & ~REG_WDATA;
        if (wr_sts2)
            next_gpio_status = next_gpio_status & ~REG_WDATA[GPIO_N-1:0];
        next_status_first = next_status_first | evt_first;
        next_gpio_status = next_gpio_status | gpio_evt;
    end

    // Sticky status registers
    always @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            wake_status_first <= 8'h00;
            gpio_status <= {GPIO_N{1'b0}};
        end
        else
        begin
            wake_status_first <= next_status_first;
            gpio_status <= next_gpio_status;
        end
    end

    // Scan code lives on standby power: only standby reset clears it,
    // so the wake key survives a main reset
    always @(posedge CORE_CLK or posedge STANDBY_RESET)
    begin
        if (STANDBY_RESET)
            wake_scan_code <= `PEWL_RST_SCAN_CODE;
        else if (wr_scan)
            wake_scan_code <= REG_WDATA;
    end

    // Control and enable registers
    always @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            event_output_control <= `PEWL_RST_EVT_OUT_CTRL;
            slow_clock_control <= `PEWL_RST_SLOW_CLK_CTRL;
            wake_enable_first <= 8'h00;
            gpio_enable <= {GPIO_N{1'b0}};
            gpio_pol <= {GPIO_N{1'b0}};
            dual_edge_wake <= {GPIO_N{1'b0}};
            global_event_enable <= 1'b0;
        end
        else
        begin
            // Fan enables must be cleared by software before main power goes
            if (wr_ctl)
                event_output_control <= REG_WDATA;
            if (wr_slow)
                slow_clock_control <= REG_WDATA;
            if (wr_en1)
                wake_enable_first <= REG_WDATA;
            if (wr_en2)
                gpio_enable <= REG_WDATA[GPIO_N-1:0];
            if (wr_pol)
                gpio_pol <= REG_WDATA[GPIO_N-1:0];
            if (wr_dual)
                dual_edge_wake <= REG_WDATA[GPIO_N-1:0];
            if (wr_glob)
                global_event_enable <= REG_WDATA[`PEWL_BIT_GLOBAL_EN];
        end
    end

    // Aggregate: any status with its enable; key bit needs its enable too
    assign aggregate_event_status = |(wake_status_first & wake_enable_first)
        | |(gpio_status & gpio_enable);

    // Output pin: asserted level follows polarity; open drain only pulls
    wire pme_active = global_event_enable & aggregate_event_status;
    wire pin_level = event_output_control[`PEWL_BIT_OUT_POL] ? pme_active
        : ~pme_active;
    reg out_q;
    reg oe_q;

    // Open drain drives only the low level; push-pull always drives.
    // Active-high open drain thus needs a pull-up to show the event.
    always @*
    begin
        next_out = pin_level;
        if (event_output_control[`PEWL_BIT_OUT_TYPE])
            next_oe = ~pin_level;
        else
            next_oe = 1'b1;
    end

    // Pin flops: reset leaves the pin released and high
    always @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            out_q <= 1'b1;
            oe_q <= 1'b0;
        end
        else
        begin
            out_q <= next_out;
            oe_q <= next_oe;
        end
    end
    assign POWER_EVENT_OUT = out_q;
    assign POWER_EVENT_OE = oe_q;

    // Read data registered one cycle after REG_RD; unmapped reads zero
    always @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
        begin
            case (REG_ADDR)
                `PEWL_OFS_SCAN_CODE: REG_RDATA <= wake_scan_code;
                `PEWL_OFS_EVT_OUT_CTRL: REG_RDATA <= event_output_control;
                `PEWL_OFS_SLOW_CLK_CTRL: REG_RDATA <= slow_clock_control;
                `PEWL_OFS_STS1: REG_RDATA <= wake_status_first;
                `PEWL_OFS_EN1: REG_RDATA <= wake_enable_first;
                `PEWL_OFS_STS2: REG_RDATA <= pad(gpio_status);
                `PEWL_OFS_EN2: REG_RDATA <= pad(gpio_enable);
                `PEWL_OFS_GPIO_POL: REG_RDATA <= pad(gpio_pol);
                `PEWL_OFS_GPIO_DUAL: REG_RDATA <= pad(dual_edge_wake);
                `PEWL_OFS_GLOBAL: REG_RDATA <= {6'h00, aggregate_event_status,
                    global_event_enable};
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end
endmodule // pewl_top

// [include/pewl_consts.vh]
// Constants for the power event wake logic: register offsets, field positions,
// reset values and timing figures. Definitions only.
`ifndef PEWL_CONSTS_VH
`define PEWL_CONSTS_VH

// Register offsets on the runtime register port
`define PEWL_OFS_SCAN_CODE 8'h11
`define PEWL_OFS_EVT_OUT_CTRL 8'h16
`define PEWL_OFS_SLOW_CLK_CTRL 8'hf0
`define PEWL_OFS_STS1 8'h20
`define PEWL_OFS_EN1 8'h21
`define PEWL_OFS_STS2 8'h22
`define PEWL_OFS_EN2 8'h23
`define PEWL_OFS_GLOBAL 8'h24
`define PEWL_OFS_GPIO_POL 8'h25
`define PEWL_OFS_GPIO_DUAL 8'h26

// Field positions
`define PEWL_BIT_OUT_POL 1
`define PEWL_BIT_OUT_TYPE 7
`define PEWL_BIT_KEY_OFF 1
`define PEWL_BIT_KEY_STS 5
`define PEWL_BIT_RING_A 0
`define PEWL_BIT_RING_B 1
`define PEWL_BIT_KBD 2
`define PEWL_BIT_MOUSE 3
`define PEWL_BIT_FAN 4
`define PEWL_BIT_GLOBAL_EN 0
`define PEWL_BIT_AGG_STS 1

// Reset values
`define PEWL_RST_EVT_OUT_CTRL 8'h80
`define PEWL_RST_SLOW_CLK_CTRL 8'h00
`define PEWL_RST_SCAN_CODE 8'h00

// Key matcher timing: idle window in microseconds, slow clock in Hz
`define PEWL_IDLE_MIN_US 115
`define PEWL_SLOW_CLK_HZ 32768
`define PEWL_FRAME_BITS 11

`endif

// [logic/pewl_edge_detect.v]
// Two-flop synchroniser with edge detect for asynchronous inputs.
// Assumes the input is a pin outside the sampling clock domain.
module pewl_edge_detect #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Pin side
    input wire [WIDTH-1:0] pin,
    // Synchronised level and edges
    output wire [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] sync;
    reg [WIDTH-1:0] prev;

    // First flop only feeds the second
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= {WIDTH{1'b0}};
            sync <= {WIDTH{1'b0}};
            prev <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule // pewl_edge_detect

// [logic/pewl_key_match.v]
// Keyboard scan code matcher, stepping on keyboard clock falls; idle window timed in slow-clock ticks.
// Assumes kbd clock/data are already synchronised and slow_tick is one cycle wide.
`include "pewl_consts.vh"
module pewl_key_match #(
    parameter IDLE_TICKS = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Enable and slow clock tick
    input wire enable,
    input wire slow_tick,
    // Synchronised keyboard lines
    input wire kbd_clk,
    input wire kbd_clk_fall,
    input wire kbd_data,
    // Programmed scan code
    input wire [7:0] scan_code,
    // One-cycle match pulse
    output reg match
);
    localparam ST_IDLE = 3'b001;
    localparam ST_ARMED = 3'b010;
    localparam ST_FRAME = 3'b100;

    reg [2:0] state;
    reg [7:0] idle_cnt;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg parity;
    reg data_ok;

    // Idle counter counts slow ticks while the clock line stays high
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            idle_cnt <= 8'h00;
        else if (!enable || !kbd_clk)
            idle_cnt <= 8'h00;
        else if (slow_tick && idle_cnt != 8'hff)
            idle_cnt <= idle_cnt + 8'h01;
    end

    // Frame sequencer; gated off entirely while disabled
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            parity <= 1'b0;
            data_ok <= 1'b0;
            match <= 1'b0;
        end
        else
        begin
            match <= 1'b0;
            if (!enable)
                state <= ST_IDLE;
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        if (idle_cnt >= IDLE_TICKS)
                            state <= ST_ARMED;
                    end
                    ST_ARMED:
                    begin
                        // Start bit taken on first falling edge after idle
                        if (kbd_clk_fall)
                        begin
                            state <= ST_FRAME;
                            bit_cnt <= 4'h1;
                            parity <= 1'b0;
                        end
                    end
                    ST_FRAME:
                    begin
                        if (idle_cnt >= IDLE_TICKS)
                            state <= ST_IDLE;
                        else if (kbd_clk_fall)
                        begin
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt <= 4'h8)
                            begin
                                shift <= {kbd_data, shift[7:1]}; // LSB first
                                parity <= parity ^ kbd_data;
                            end
                            else if (bit_cnt == 4'h9)
                            begin
                                // Compare sampled at edge 10, with parity
                                data_ok <= (shift == scan_code)
                                    && (parity ^ kbd_data);
                            end
                            else
                            begin
                                // Eleventh edge: stop bit, then back to search
                                match <= data_ok && kbd_data;
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // pewl_key_match

// [verif/pewl_top_properties.sv]
// Checker for the power event wake logic top: event pin and register reads.
// Assumes registers change only through the top module's register port.
module pewl_top_properties (
    // Clock and resets
    input wire CORE_CLK,
    input wire RESET,
    input wire STANDBY_RESET,
    // Register port
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_WDATA,
    input wire [7:0] REG_RDATA,
    // Watched pins
    input wire RING_INDICATOR_A_N,
    input wire POWER_EVENT_OUT,
    input wire POWER_EVENT_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] ctl;
    reg [7:0] slow;
    reg [7:0] scan;
    reg [7:0] en1;
    reg gen;
    reg [1:0] age;
    // Shadow registers; age counts quiet cycles, since the pin lags a control write
    always @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ctl <= 8'h80;
            slow <= 8'h00;
            en1 <= 8'h00;
            gen <= 1'b0;
            age <= 2'h3;
        end
        else
        begin
            if (REG_WR && REG_ADDR == 8'h16)
                ctl <= REG_WDATA;
            if (REG_WR && REG_ADDR == 8'hf0)
                slow <= REG_WDATA;
            if (REG_WR && REG_ADDR == 8'h21)
                en1 <= REG_WDATA;
            if (REG_WR && REG_ADDR == 8'h24)
                gen <= REG_WDATA[0];
            if (REG_WR && (REG_ADDR == 8'h16 || REG_ADDR == 8'h24))
                age <= 2'h0;
            else if (age != 2'h3)
                age <= age + 2'h1;
        end
    end
    // Scan code shadow lives on standby power only
    always @(posedge CORE_CLK or posedge STANDBY_RESET)
    begin
        if (STANDBY_RESET)
            scan <= 8'h00;
        else if (REG_WR && REG_ADDR == 8'h11)
            scan <= REG_WDATA;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    AST_RESET_RELEASED: assert property ($fell(RESET) |-> !POWER_EVENT_OE)
        else $error("event pin driven right after reset");
    AST_PUSH_PULL_DRIVES: assert property (age == 2'h3 && !ctl[7] |-> POWER_EVENT_OE)
        else $error("push-pull pin not driven");
    AST_ACTIVE_LEVEL: assert property (age == 2'h3 && ctl[7] && POWER_EVENT_OE
        |-> !POWER_EVENT_OUT) else $error("open-drain pin drives wrong level");
    AST_GLOBAL_OFF: assert property (age == 2'h3 && !gen
        |-> (POWER_EVENT_OE ? POWER_EVENT_OUT : 1'b1) != ctl[1])
        else $error("event asserted with global enable clear");
    AST_RING_WAKE: assert property ($fell(RING_INDICATOR_A_N) && en1[0] && gen && age == 2'h3
        |-> ##[2:6] ((POWER_EVENT_OE ? POWER_EVENT_OUT : 1'b1) == ctl[1]))
        else $error("ring event not seen on the pin");
    AST_CTL_READ: assert property (REG_RD && !REG_WR && REG_ADDR == 8'h16
        |=> REG_RDATA == ctl) else $error("event control readback wrong");
    AST_SLOW_READ: assert property (REG_RD && !REG_WR && REG_ADDR == 8'hf0
        |=> REG_RDATA == slow) else $error("slow clock control readback wrong");
    AST_SCAN_READ: assert property (REG_RD && !REG_WR && REG_ADDR == 8'h11
        |=> REG_RDATA == scan) else $error("scan code readback wrong");
endmodule // pewl_top_properties

bind pewl_top pewl_top_properties u_pewl_top_properties (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .STANDBY_RESET(STANDBY_RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .RING_INDICATOR_A_N(RING_INDICATOR_A_N),
    .POWER_EVENT_OUT(POWER_EVENT_OUT), .POWER_EVENT_OE(POWER_EVENT_OE));

// [verif/pewl_chipset_model.sv]
// Chipset side of the power event wire: pull-up and resolved level.
// Assumes no other device pulls the wire.
module pewl_chipset_model (
    // Pin from the device
    input wire pin_out,
    input wire pin_oe,
    // Level the chipset sees
    output wire line
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin floats to the pull-up, so idle active-low open drain reads high
    assign line = pin_oe ? pin_out : 1'b1;
endmodule // pewl_chipset_model

// [verif/power_event_wake_logic_tb_top.sv]
// Self-checking bench for the power event wake logic top.
// Assumes the chipset model resolves the pin; keyboard frames come from here.
module power_event_wake_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg CORE_CLK = 1'b0;
    reg RESET = 1'b1;
    reg STANDBY_RESET = 1'b1;
    reg MAIN_POWER_OK = 1'b0;
    reg [7:0] REG_ADDR = 8'h00;
    reg [7:0] REG_WDATA = 8'h00;
    reg REG_WR = 1'b0;
    reg REG_RD = 1'b0;
    reg [4:0] src = 5'h0f;
    reg KBD_CLK = 1'b1;
    reg [7:0] GPIO_IN = 8'h00;
    reg SLOW_CLK = 1'b0;
    reg [3:0] sdiv = 4'h0;
    wire [7:0] REG_RDATA;
    wire POWER_EVENT_OUT;
    wire POWER_EVENT_OE;
    wire line;
    integer n_errors = 0;
    integer tests_run = 0;
    integer i;
    integer k;
    integer g;
    reg [7:0] d;
    reg [7:0] code;
    reg [7:0] b;
    pewl_top #(.GPIO_N(8), .IDLE_TICKS(2)) u_pewl_top (.CORE_CLK(CORE_CLK), .RESET(RESET),
        .STANDBY_RESET(STANDBY_RESET), .MAIN_POWER_OK(MAIN_POWER_OK), .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .RING_INDICATOR_A_N(src[0]), .RING_INDICATOR_B_N(src[1]), .KBD_DATA(src[2]),
        .KBD_CLK(KBD_CLK), .MOUSE_DATA(src[3]), .FAN_EVENT(src[4]), .GPIO_IN(GPIO_IN),
        .SLOW_CLK(SLOW_CLK), .POWER_EVENT_OUT(POWER_EVENT_OUT), .POWER_EVENT_OE(POWER_EVENT_OE));
    pewl_chipset_model u_pewl_chipset_model (.pin_out(POWER_EVENT_OUT),
        .pin_oe(POWER_EVENT_OE), .line(line));
    // Core clock, 100 MHz
    always #5 CORE_CLK = ~CORE_CLK;
    // Slow clock at 5 MHz keeps idle windows short; matcher runs with two ticks
    always @(posedge CORE_CLK)
    begin
        if (sdiv == 4'h9)
        begin
            sdiv <= 4'h0;
            SLOW_CLK <= ~SLOW_CLK;
        end
        else
            sdiv <= sdiv + 4'h1;
    end
    task cyc(input integer n);
        repeat (n) @(posedge CORE_CLK);
    endtask
    task wr(input [7:0] a, input [7:0] v);
    begin
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // Read, mask and compare; data is taken a full cycle after the strobe edge
    task rchk(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        @(posedge CORE_CLK);
        #1 d = REG_RDATA;
        chk(d & m, e);
    end
    endtask
    // Toggle a source away from idle and back; each source acts on one of the edges
    task pulse(input integer n);
    begin
        src[n] <= ~src[n];
        cyc(5);
        src[n] <= ~src[n];
        cyc(6);
    end
    endtask
    // Keyboard frame, LSB first, 80 ns link clock after a long clock-high idle
    task frame(input [7:0] v, input bad, input integer n);
        reg [10:0] bits;
        integer j;
    begin
        bits = {1'b1, (~^v) ^ bad, v, 1'b0};
        cyc(200);
        for (j = 0; j < n; j = j + 1)
        begin
            src[2] <= bits[j];
            cyc(2);
            KBD_CLK <= 1'b0;
            cyc(4);
            KBD_CLK <= 1'b1;
            cyc(2);
        end
        src[2] <= 1'b1;
    end
    endtask
    function [7:0] key_exp(input [7:0] sent, input [7:0] c, input bad, input off);
        key_exp = (sent == c && !bad && !off) ? 8'h20 : 8'h00;
    endfunction
    task finish_test;
    begin
        $display("counts: %0d checks, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // Watchdog well beyond the few thousand cycles the sequence needs
    initial
    begin
        cyc(20000);
        n_errors = n_errors + 1;
        $display("unexpected at %0t: watchdog got %h expected %h", $time, 8'h00, 8'h01);
        finish_test;
    end
    // Main sequence
    initial
    begin
        i = $urandom(4);
        cyc(10);
        RESET <= 1'b0;
        STANDBY_RESET <= 1'b0;
        cyc(2);
        rchk(8'h16, 8'hff, 8'h80);
        rchk(8'hf0, 8'hff, 8'h00);
        chk({7'h0, line}, 8'h01);
        $display("test reset defaults done");
        wr(8'h21, 8'h01);
        pulse(0);
        rchk(8'h20, 8'h01, 8'h01);
        chk({7'h0, line}, 8'h01);
        wr(8'h24, 8'h01);
        cyc(3);
        chk({7'h0, line}, 8'h00);
        rchk(8'h24, 8'h02, 8'h02);
        wr(8'h16, 8'h02);
        cyc(3);
        chk({6'h0, POWER_EVENT_OE, POWER_EVENT_OUT}, 8'h03);
        wr(8'h20, 8'h00);
        rchk(8'h20, 8'h01, 8'h01);
        wr(8'h20, 8'h01);
        cyc(3);
        chk({6'h0, POWER_EVENT_OE, POWER_EVENT_OUT}, 8'h02);
        rchk(8'h24, 8'h02, 8'h00);
        wr(8'h16, 8'h80);
        cyc(4);
        $display("test ring and pin done");
        for (i = 0; i < 6; i = i + 1)
        begin
            MAIN_POWER_OK <= (i != 4);
            pulse((i == 5) ? 4 : i);
            rchk(8'h20, 8'h1f, (i == 4) ? 8'h00 : 8'h01 << ((i == 5) ? 4 : i));
            wr(8'h20, 8'hff);
        end
        $display("test sources done");
        g = $urandom % 8;
        wr(8'h23, 8'h01 << g);
        for (k = 0; k < 3; k = k + 1)
        begin
            wr(8'h25, (k == 1) ? 8'h01 << g : 8'h00);
            wr(8'h26, (k == 2) ? 8'h01 << g : 8'h00);
            cyc(6);
            wr(8'h22, 8'hff);
            GPIO_IN[g] <= 1'b1;
            cyc(6);
            rchk(8'h22, 8'hff, (k == 1) ? 8'h00 : 8'h01 << g);
            wr(8'h22, 8'hff);
            GPIO_IN[g] <= 1'b0;
            cyc(6);
            rchk(8'h22, 8'hff, (k == 0) ? 8'h00 : 8'h01 << g);
        end
        $display("test gpio edges done");
        code = $urandom;
        wr(8'h11, code);
        wr(8'h21, 8'h20);
        for (k = 0; k < 5; k = k + 1)
        begin
            wr(8'hf0, (k == 4) ? 8'h02 : 8'h00);
            wr(8'h20, 8'hff);
            if (k == 3)
                frame(code, 1'b0, 4);
            b = (k == 1) ? code ^ (8'h01 << ($urandom % 8)) : code;
            frame(b, k == 2, 11);
            cyc(20);
            rchk(8'h20, 8'h20, key_exp(b, code, k == 2, k == 4));
            if (k == 0)
                chk({7'h0, line}, 8'h00);
        end
        $display("test key match done");
        wr(8'hf0, 8'h00);
        RESET <= 1'b1;
        cyc(3);
        RESET <= 1'b0;
        cyc(2);
        rchk(8'h11, 8'hff, code);
        STANDBY_RESET <= 1'b1;
        cyc(3);
        STANDBY_RESET <= 1'b0;
        cyc(2);
        rchk(8'h11, 8'hff, 8'h00);
        $display("test standby reset done");
        finish_test;
    end
endmodule // power_event_wake_logic_tb_top
